// ===== hdl/acs_defines.svh
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// register byte addresses
`define ACS_ADDR_MODE0 12'h000
`define ACS_ADDR_MODE1 12'h004
`define ACS_ADDR_CHSEL 12'h008
`define ACS_ADDR_RES10 12'h00C
`define ACS_ADDR_RES8 12'h010
`define ACS_ADDR_ULIM 12'h014
`define ACS_ADDR_LLIM 12'h018
`define ACS_ADDR_STAT 12'h01C

// mode register 0 fields
`define ACS_M0_ENABLE 0
`define ACS_M0_START 7
`define ACS_M0_HWMODE 1
`define ACS_M0_ONESHOT 2
// mode register 1 fields
`define ACS_M1_TRGSEL 0
`define ACS_M1_RANGE 1
// status register fields
`define ACS_ST_BUSY 0
`define ACS_ST_HWSTBY 1
`define ACS_ST_ON 2
`define ACS_ST_IRQ 3

// reset values
`define ACS_RST_ULIM 8'hFF
`define ACS_RST_LLIM 8'h00
`define ACS_RST_CNT 6'h00

// stabilization time, for reference by software
`define ACS_STAB_NS 1000
`define ACS_CLK_NS 50
`define ACS_STAB_CYC ((`ACS_STAB_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)

`endif

// ===== hdl/acs_pkg.sv
package acs_pkg;

    typedef enum logic [1:0] {
        ACS_STOP,
        ACS_STANDBY,
        ACS_HW_STANDBY,
        ACS_CONVERT
    } acs_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } acs_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } acs_apb_rsp_t;

    typedef struct packed {
        logic [9:0] res10;
        logic [7:0] res8;
    } acs_result_t;

    typedef struct packed {
        acs_state_t state;
        logic enable;
        logic start;
        logic hw_mode;
        logic one_shot;
        logic trg_sel;
        logic range_chk;
        logic [4:0] chan;
        logic [7:0] ulim;
        logic [7:0] llim;
        logic [5:0] cnt;
        logic [9:0] sar;
        acs_result_t res;
        logic irq;
        logic [1:0] rtc_sync;
        logic [1:0] itv_sync;
        logic trg_prev;
        logic [9:0] ain_sync1;
        logic [9:0] ain_sync2;
        acs_apb_rsp_t rsp;
    } acs_regs_t;

endpackage

// ===== hdl/acs_sequencer.sv
`timescale 1ns/1ps
`include "acs_defines.svh"

module acs_sequencer #(
    parameter int CONV_CYCLES = 12
) (
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic [31:0] PRDATA_O,
    // trigger sources and analog sample
    input wire logic RTC_EVENT_TRIGGER_I,
    input wire logic INTERVAL_TIMER_TRIGGER_I,
    input wire logic [9:0] ANALOG_SAMPLE_I,
    // converter side
    output logic [4:0] CHANNEL_O,
    output logic CONVERTING_O,
    output logic CONVERTER_ON_O,
    output logic CONVERSION_END_IRQ_O
);
    import acs_pkg::*;

    acs_regs_t r_reg;
    acs_regs_t r_next;
    acs_apb_req_t req;
    logic wr_access;
    logic rd_access;
    logic wr_mode0;
    logic wr_chsel;
    logic trg_level;
    logic trg_event;
    logic conv_done;
    logic in_range;
    logic [9:0] sample_val;
    logic new_start;
    logic new_enable;
    logic restart;

    assign req = '{psel: PSEL_I, penable: PENABLE_I, pwrite: PWRITE_I,
                   paddr: PADDR_I, pwdata: PWDATA_I};

    always_comb begin
        r_next = r_reg;
        // apb answers in the access phase's second cycle, one wait state
        wr_access = req.psel && req.penable && req.pwrite && !r_reg.rsp.pready;
        rd_access = req.psel && !req.penable && !req.pwrite;
        wr_mode0 = wr_access && (req.paddr == `ACS_ADDR_MODE0);
        wr_chsel = wr_access && (req.paddr == `ACS_ADDR_CHSEL);
        new_enable = r_reg.enable;
        new_start = r_reg.start;
        restart = 1'b0;
        sample_val = r_reg.ain_sync2;
        in_range = 1'b1;

        // pins pass two flops before use
        r_next.rtc_sync = {r_reg.rtc_sync[0], RTC_EVENT_TRIGGER_I};
        r_next.itv_sync = {r_reg.itv_sync[0], INTERVAL_TIMER_TRIGGER_I};
        r_next.ain_sync1 = ANALOG_SAMPLE_I;
        r_next.ain_sync2 = r_reg.ain_sync1;
        trg_level = r_reg.trg_sel ? r_reg.itv_sync[1] : r_reg.rtc_sync[1];
        r_next.trg_prev = trg_level;
        trg_event = trg_level && !r_reg.trg_prev;

        r_next.rsp.pready = req.psel && req.penable && !r_reg.rsp.pready;
        r_next.irq = 1'b0;

        if (wr_access) begin
            case (req.paddr)
                `ACS_ADDR_MODE0: begin
                    new_enable = req.pwdata[`ACS_M0_ENABLE];
                    new_start = req.pwdata[`ACS_M0_START] && new_enable;
                    r_next.hw_mode = req.pwdata[`ACS_M0_HWMODE];
                    r_next.one_shot = req.pwdata[`ACS_M0_ONESHOT];
                end
                `ACS_ADDR_MODE1: begin
                    r_next.trg_sel = req.pwdata[`ACS_M1_TRGSEL];
                    r_next.range_chk = req.pwdata[`ACS_M1_RANGE];
                end
                `ACS_ADDR_CHSEL: r_next.chan = req.pwdata[4:0];
                `ACS_ADDR_ULIM: r_next.ulim = req.pwdata[7:0];
                `ACS_ADDR_LLIM: r_next.llim = req.pwdata[7:0];
                // results and status are read only; unmapped writes dropped
                default: ;
            endcase
        end
        if (rd_access) begin
            r_next.rsp.prdata = '0;
            case (req.paddr)
                `ACS_ADDR_MODE0: begin
                    r_next.rsp.prdata[`ACS_M0_ENABLE] = r_reg.enable;
                    r_next.rsp.prdata[`ACS_M0_START] = r_reg.start;
                    r_next.rsp.prdata[`ACS_M0_HWMODE] = r_reg.hw_mode;
                    r_next.rsp.prdata[`ACS_M0_ONESHOT] = r_reg.one_shot;
                end
                `ACS_ADDR_MODE1: begin
                    r_next.rsp.prdata[`ACS_M1_TRGSEL] = r_reg.trg_sel;
                    r_next.rsp.prdata[`ACS_M1_RANGE] = r_reg.range_chk;
                end
                `ACS_ADDR_CHSEL: r_next.rsp.prdata[4:0] = r_reg.chan;
                // 10-bit result left aligned in a 16-bit field
                `ACS_ADDR_RES10: r_next.rsp.prdata[15:6] = r_reg.res.res10;
                `ACS_ADDR_RES8: r_next.rsp.prdata[7:0] = r_reg.res.res8;
                `ACS_ADDR_ULIM: r_next.rsp.prdata[7:0] = r_reg.ulim;
                `ACS_ADDR_LLIM: r_next.rsp.prdata[7:0] = r_reg.llim;
                `ACS_ADDR_STAT: begin
                    r_next.rsp.prdata[`ACS_ST_BUSY] = (r_reg.state == ACS_CONVERT);
                    r_next.rsp.prdata[`ACS_ST_HWSTBY] = (r_reg.state == ACS_HW_STANDBY);
                    r_next.rsp.prdata[`ACS_ST_ON] = (r_reg.state != ACS_STOP);
                    r_next.rsp.prdata[`ACS_ST_IRQ] = r_reg.irq;
                end
                default: ;
            endcase
        end
        // error decided in setup, so it never sticks to a later transfer
        if (req.psel && !req.penable) begin
            r_next.rsp.pslverr = !(req.paddr inside {`ACS_ADDR_MODE0,
                `ACS_ADDR_MODE1, `ACS_ADDR_CHSEL, `ACS_ADDR_RES10, `ACS_ADDR_RES8,
                `ACS_ADDR_ULIM, `ACS_ADDR_LLIM, `ACS_ADDR_STAT});
        end

        r_next.enable = new_enable;
        r_next.start = new_start;
        conv_done = (r_reg.state == ACS_CONVERT) &&
                    (r_reg.cnt == 6'(CONV_CYCLES - 1));
        // compare upper eight result bits with limits
        if (r_reg.range_chk) begin
            in_range = (sample_val[9:2] <= r_reg.ulim) &&
                       (sample_val[9:2] >= r_reg.llim);
        end

        case (r_reg.state)
            ACS_STOP: begin
                // enable only powers up to standby
                if (new_enable) begin
                    r_next.state = ACS_STANDBY;
                end
            end
            ACS_STANDBY, ACS_HW_STANDBY: begin
                if (!new_enable && !new_start) begin
                    r_next.state = ACS_STOP;
                end else if (!new_start) begin
                    r_next.state = ACS_STANDBY;
                end else if (!r_reg.hw_mode || r_next.hw_mode == 1'b0) begin
                    if (!r_next.hw_mode) begin
                        restart = 1'b1;
                    end else begin
                        r_next.state = ACS_HW_STANDBY;
                    end
                end else if (trg_event) begin
                    restart = 1'b1;
                end else begin
                    r_next.state = ACS_HW_STANDBY;
                end
            end
            ACS_CONVERT: begin
                if (!new_start) begin
                    r_next.state = new_enable ? ACS_STANDBY : ACS_STOP;
                end else if ((wr_mode0 && req.pwdata[`ACS_M0_START]) || wr_chsel) begin
                    // abort and restart, partial data dropped
                    restart = 1'b1;
                end else if (r_reg.hw_mode && trg_event) begin
                    // trigger restarts; software mode ignores it
                    restart = 1'b1;
                end else if (conv_done) begin
                    if (in_range) begin
                        r_next.res.res10 = sample_val;
                        r_next.res.res8 = sample_val[9:2];
                        r_next.irq = 1'b1;
                    end
                    if (!r_reg.one_shot) begin
                        restart = 1'b1;
                    end else if (!r_reg.hw_mode) begin
                        r_next.start = 1'b0;
                        r_next.state = ACS_STANDBY;
                    end else begin
                        // start stays 1, wait next trigger
                        r_next.state = ACS_HW_STANDBY;
                    end
                end else begin
                    r_next.cnt = r_reg.cnt + 6'h01;
                end
            end
            default: r_next.state = ACS_STOP;
        endcase

        if (restart) begin
            r_next.state = ACS_CONVERT;
            r_next.cnt = `ACS_RST_CNT;
        end
        r_next.sar = (r_next.state == ACS_CONVERT) ? sample_val : r_reg.sar;
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            r_reg <= '0;
            r_reg.state <= ACS_STOP;
            r_reg.ulim <= `ACS_RST_ULIM;
            r_reg.llim <= `ACS_RST_LLIM;
            r_reg.cnt <= `ACS_RST_CNT;
        end else begin
            r_reg <= r_next;
        end
    end

    assign PREADY_O = r_reg.rsp.pready;
    assign PSLVERR_O = r_reg.rsp.pslverr && r_reg.rsp.pready;
    assign PRDATA_O = r_reg.rsp.prdata;
    assign CHANNEL_O = r_reg.chan;
    assign CONVERTING_O = (r_reg.state == ACS_CONVERT);
    assign CONVERTER_ON_O = (r_reg.state != ACS_STOP);
    assign CONVERSION_END_IRQ_O = r_reg.irq;

endmodule // acs_sequencer

// ===== test/acs_seq_checker.sv
`timescale 1ns/1ps
module acs_seq_checker #(
    parameter int CONV_CYCLES = 12
) (
    // clock, reset, bus
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    input wire logic PSEL_I,
    input wire logic PWRITE_I,
    // triggers and converter side
    input wire logic RTC_EVENT_TRIGGER_I,
    input wire logic INTERVAL_TIMER_TRIGGER_I,
    input wire logic [4:0] CHANNEL_O,
    input wire logic CONVERTING_O,
    input wire logic CONVERTER_ON_O,
    input wire logic CONVERSION_END_IRQ_O
);
    logic [7:0] run_reg;
    // cycles of conversion with no result; any write or trigger may restart it
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            run_reg <= 8'h00;
        end else if (!CONVERTING_O || CONVERSION_END_IRQ_O || PSEL_I || RTC_EVENT_TRIGGER_I
                     || INTERVAL_TIMER_TRIGGER_I) begin
            run_reg <= 8'h00;
        end else if (run_reg != 8'hFF) begin
            run_reg <= run_reg + 8'h01;
        end
    end
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_N_I);
    AST_IRQ_PULSE: assert property (CONVERSION_END_IRQ_O |=> !CONVERSION_END_IRQ_O)
        else $error("end interrupt longer than one cycle");
    AST_IRQ_AFTER_RUN: assert property (CONVERSION_END_IRQ_O |-> $past(CONVERTING_O))
        else $error("end interrupt without a conversion");
    AST_RUN_NEEDS_ON: assert property (CONVERTING_O |-> CONVERTER_ON_O)
        else $error("converting while converter off");
    AST_NO_START_OFF: assert property ($rose(CONVERTING_O) |-> $past(CONVERTER_ON_O))
        else $error("conversion started while disabled");
    AST_ENABLE_IDLE: assert property ($rose(CONVERTER_ON_O) |-> !CONVERTING_O)
        else $error("enable started a conversion");
    AST_CHAN_BY_WRITE: assert property ($changed(CHANNEL_O) |-> $past(PSEL_I && PWRITE_I))
        else $error("channel changed without a write");
    AST_STOP_BY_WRITE: assert property ($fell(CONVERTER_ON_O) |-> $past(PSEL_I && PWRITE_I))
        else $error("converter stopped without a write");
    AST_RUN_BOUNDED: assert property (run_reg <= CONV_CYCLES + 6)
        else $error("conversion ran too long without result");
    cover property (CONVERSION_END_IRQ_O);
    cover property ($rose(CONVERTING_O));
    cover property ($fell(CONVERTER_ON_O));
endmodule // acs_seq_checker

bind acs_sequencer acs_seq_checker #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
    .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PWRITE_I(PWRITE_I),
    .RTC_EVENT_TRIGGER_I(RTC_EVENT_TRIGGER_I),
    .INTERVAL_TIMER_TRIGGER_I(INTERVAL_TIMER_TRIGGER_I), .CHANNEL_O(CHANNEL_O),
    .CONVERTING_O(CONVERTING_O), .CONVERTER_ON_O(CONVERTER_ON_O),
    .CONVERSION_END_IRQ_O(CONVERSION_END_IRQ_O));

// ===== test/acs_trig_model.sv
`timescale 1ns/1ps
module acs_trig_model (
    input wire logic clk_i,
    output logic rtc_o,
    output logic itv_o,
    output logic [9:0] sample_o
);
    initial begin
        rtc_o = 1'b0;
        itv_o = 1'b0;
        sample_o = 10'h000;
    end
    task automatic fire(input logic use_itv);
        @(posedge clk_i);
        if (use_itv) itv_o <= 1'b1; else rtc_o <= 1'b1;
        // held a few cycles so the synchroniser sees it
        repeat (4) @(posedge clk_i);
        rtc_o <= 1'b0;
        itv_o <= 1'b0;
        @(negedge clk_i);
    endtask
    task automatic set_sample(input logic [9:0] v);
        @(posedge clk_i);
        sample_o <= v;
    endtask
endmodule // acs_trig_model

// ===== test/tb_top.sv
`timescale 1ns/1ps
`include "acs_defines.svh"
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_total++; \
    $display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb_top;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, er;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0000_0000, rd;
    wire logic rdy, serr, conv, on, irq, rtc, itv;
    wire logic [31:0] prd;
    wire logic [4:0] ch;
    wire logic [9:0] smp;
    int err_total = 0, num_checks = 0, cyc = 0, irqs = 0, n0;
    always #25 clk = ~clk;
    acs_sequencer #(.CONV_CYCLES(10)) u_dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PREADY_O(rdy),
        .PSLVERR_O(serr), .PRDATA_O(prd), .RTC_EVENT_TRIGGER_I(rtc),
        .INTERVAL_TIMER_TRIGGER_I(itv), .ANALOG_SAMPLE_I(smp), .CHANNEL_O(ch),
        .CONVERTING_O(conv), .CONVERTER_ON_O(on), .CONVERSION_END_IRQ_O(irq));
    acs_trig_model u_src (.clk_i(clk), .rtc_o(rtc), .itv_o(itv), .sample_o(smp));
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) irqs <= irqs + 1;
        if (cyc == 20000) begin
            err_total++;
            give_verdict;
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; pwr <= w; pa <= a; pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        // no fixed latency assumed; the global cycle limit ends a hang
        while (rdy !== 1'b1) @(posedge clk);
        rd = prd;
        er = serr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(negedge clk);
    endtask
    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 60) begin @(negedge clk); n++; end
        `CHK("irq", 1'b1, irq)
        @(negedge clk);
    endtask
    task automatic t_regs;
        apb(0, `ACS_ADDR_ULIM, 0); `CHK("ulim", 32'h0000_00FF, rd)
        apb(0, `ACS_ADDR_LLIM, 0); `CHK("llim", 32'h0000_0000, rd)
        apb(0, 12'h020, 0); `CHK("slverr", 1'b1, er)
        $display("test regs done");
    endtask
    task automatic t_sw_seq;
        u_src.set_sample(10'h2A5);
        apb(1, `ACS_ADDR_MODE0, 1); `CHK("on", 1'b1, on)
        `CHK("conv", 1'b0, conv)
        repeat (`ACS_STAB_CYC) @(negedge clk); // settle wait
        apb(1, `ACS_ADDR_CHSEL, 3); `CHK("chan", 5'h03, ch)
        apb(1, `ACS_ADDR_MODE0, 32'h0000_0081); `CHK("conv", 1'b1, conv)
        wait_irq;
        apb(0, `ACS_ADDR_RES10, 0); `CHK("res10", 32'h0000_A940, rd)
        apb(0, `ACS_ADDR_RES8, 0); `CHK("res8", 32'h0000_00A9, rd)
        wait_irq;
        apb(1, `ACS_ADDR_MODE0, 1); `CHK("conv", 1'b0, conv)
        u_src.fire(1'b0); repeat (6) @(negedge clk); `CHK("conv", 1'b0, conv)
        apb(1, `ACS_ADDR_MODE0, 0); `CHK("on", 1'b0, on)
        apb(1, `ACS_ADDR_MODE0, 32'h0000_0080); `CHK("conv", 1'b0, conv)
        apb(0, `ACS_ADDR_MODE0, 0); `CHK("start", 1'b0, rd[7])
        $display("test software sequential done");
    endtask
    task automatic t_sw_one;
        apb(1, `ACS_ADDR_MODE0, 5); apb(1, `ACS_ADDR_MODE0, 32'h0000_0085);
        n0 = irqs;
        apb(1, `ACS_ADDR_MODE0, 32'h0000_0085); `CHK("conv", 1'b1, conv)
        apb(1, `ACS_ADDR_CHSEL, 5); `CHK("chan", 5'h05, ch)
        `CHK("irqs", n0, irqs)
        wait_irq;
        repeat (14) @(negedge clk); `CHK("irqs", n0 + 1, irqs)
        `CHK("conv", 1'b0, conv)
        apb(0, `ACS_ADDR_MODE0, 0); `CHK("start", 1'b0, rd[7])
        $display("test software one-shot done");
    endtask
    task automatic t_hw;
        apb(1, `ACS_ADDR_MODE0, 3); apb(1, `ACS_ADDR_MODE0, 32'h0000_0083);
        `CHK("conv", 1'b0, conv)
        apb(0, `ACS_ADDR_STAT, 0); `CHK("hwstby", 1'b1, rd[1])
        u_src.fire(1'b0); `CHK("conv", 1'b1, conv)
        n0 = irqs;
        u_src.fire(1'b0); `CHK("irqs", n0, irqs)
        wait_irq;
        apb(1, `ACS_ADDR_MODE0, 32'h0000_0087);
        wait_irq;
        repeat (2) @(negedge clk); `CHK("conv", 1'b0, conv)
        apb(0, `ACS_ADDR_MODE0, 0); `CHK("start", 1'b1, rd[7])
        apb(1, `ACS_ADDR_MODE1, 1); u_src.fire(1'b0); `CHK("conv", 1'b0, conv)
        u_src.fire(1'b1); `CHK("conv", 1'b1, conv)
        apb(1, `ACS_ADDR_MODE0, 7); `CHK("conv", 1'b0, conv)
        `CHK("on", 1'b1, on)
        u_src.fire(1'b1); repeat (4) @(negedge clk); `CHK("conv", 1'b0, conv)
        apb(1, `ACS_ADDR_MODE0, 0); apb(1, `ACS_ADDR_MODE1, 0);
        $display("test hardware trigger done");
    endtask
    task automatic t_range;
        apb(1, `ACS_ADDR_ULIM, 32'h0000_0040); apb(1, `ACS_ADDR_MODE1, 2);
        apb(1, `ACS_ADDR_MODE0, 5);
        n0 = irqs;
        apb(1, `ACS_ADDR_MODE0, 32'h0000_0085);
        repeat (20) @(negedge clk); `CHK("irqs", n0, irqs)
        apb(0, `ACS_ADDR_RES8, 0); `CHK("res8", 32'h0000_00A9, rd)
        u_src.set_sample(10'h0FF);
        apb(1, `ACS_ADDR_MODE0, 32'h0000_0085);
        wait_irq;
        apb(0, `ACS_ADDR_RES8, 0); `CHK("res8", 32'h0000_003F, rd)
        $display("test range check done");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        t_regs;
        t_sw_seq;
        t_sw_one;
        t_hw;
        t_range;
        give_verdict;
    end
endmodule // tb_top
